// ==== common/asc_pkg.sv ====
// Constants and types shared by the sequence step controller and its FIFOs
`default_nettype none
package asc_pkg;
  localparam int NSEQ   = 4;
  localparam int NSLOT  = 17;
  localparam int CFG_W  = 12;
  localparam int DATA_W = 12;
  localparam int FIFO_DEPTH = 16;
  // Step configuration word layout
  localparam int F_CHAN_LSB = 0;
  localparam int F_CHAN_MSB = 3;
  localparam int F_DIFF     = 4;
  localparam int F_TS       = 5;
  localparam int F_IRQ      = 6;
  localparam int F_LAST     = 7;
  localparam int F_CMP_EN   = 8;
  localparam int F_CMP_LSB  = 9;
  localparam int F_CMP_MSB  = 11;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
  // First slot and highest step index of each sequence
  localparam logic [4:0] SEQ_BASE [NSEQ] = '{5'h00, 5'h08, 5'h0c, 5'h10};
  localparam logic [2:0] SEQ_LAST [NSEQ] = '{3'h7, 3'h3, 3'h3, 3'h0};
  typedef logic [1:0]        asc_seq_t;
  typedef logic [2:0]        asc_step_t;
  typedef logic [CFG_W-1:0]  asc_cfg_t;
  typedef logic [DATA_W-1:0] asc_data_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STORE} asc_state_t;
endpackage : asc_pkg
`default_nettype wire

// ==== common/asc_fifo_if.sv ====
// Valid/ready carrier between the controller and one result FIFO
`default_nettype none
interface asc_fifo_if #(parameter int W = 12);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport ctrl (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : asc_fifo_if
`default_nettype wire

// ==== hw/asc_fifo.sv ====
// Synchronous result FIFO with valid/ready on both sides
`default_nettype none
module asc_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  asc_fifo_if.fifo q
);
  import asc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic         full;
  logic         empty;

  assign empty      = (wp_r == rp_r);
  assign full       = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign q.wr_ready = !full;
  assign q.rd_valid = !empty;
  assign q.rd_data  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_r <= '0;
    end else if (q.wr_valid && !full) begin
      wp_r <= wp_r + 1'b1;
    end
  end

  // Pointer only moves on a real pop, so reading empty leaves state alone
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rp_r <= '0;
    end else if (q.rd_ready && !empty) begin
      rp_r <= rp_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (q.wr_valid && !full) begin
      mem_r[wp_r[AW-1:0]] <= q.wr_data;
    end
  end
endmodule : asc_fifo
`default_nettype wire

// ==== hw/asc_step_ctrl.sv ====
// Sample sequencer step control: step storage, execution, result FIFOs, flags
`default_nettype none
module asc_step_ctrl (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic           cfg_wr,
  input  wire asc_pkg::asc_seq_t  sequence_index,
  input  wire asc_pkg::asc_step_t step_index,
  input  wire asc_pkg::asc_cfg_t  step_config_word,
  input  wire logic [3:0]     seq_en,
  input  wire logic [3:0]     seq_trig,
  output logic                conv_req_r,
  output logic [3:0]          conv_chan_r,
  output logic                conv_diff_r,
  output logic                conv_temp_r,
  input  wire logic           conv_done,
  input  wire asc_pkg::asc_data_t conv_data,
  output logic                cmp_valid_r,
  output logic [2:0]          cmp_sel_r,
  output asc_pkg::asc_data_t  cmp_data_r,
  output logic [3:0]          seq_irq_r,
  output logic [3:0]          seq_busy_r,
  input  wire logic           rd_req,
  input  wire asc_pkg::asc_seq_t  rd_seq,
  output logic                rd_valid_r,
  output asc_pkg::asc_data_t  rd_data_r,
  output logic [3:0]          uflow_r,
  input  wire logic [3:0]     uflow_clr,
  output logic [3:0]          ovf_r,
  input  wire logic [3:0]     ovf_clr
);
  import asc_pkg::*;

  asc_cfg_t   cfg_mem_r [NSLOT];
  asc_state_t state_r;
  asc_seq_t   cur_seq_r;
  asc_step_t  step_r;
  asc_data_t  smp_r;
  logic [3:0] pend_r;
  logic [3:0] fifo_wr_ready;
  logic [3:0] fifo_not_empty;
  asc_data_t  fifo_rd_data [NSEQ];
  asc_cfg_t   cur_cfg;
  asc_cfg_t   nxt_cfg;
  logic       pick_any;
  asc_seq_t   pick_seq;
  logic       step_ok;
  logic       step_end;
  logic       rd_empty;

  // Configuration writes outside a sequence's step range are dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NSLOT; k++) begin
        cfg_mem_r[k] <= CFG_RESET;
      end
    end else if (cfg_wr && step_index <= SEQ_LAST[sequence_index]) begin
      cfg_mem_r[5'(SEQ_BASE[sequence_index] + 5'(step_index))] <= step_config_word;
    end
  end

  // Lowest pending sequence wins; this fixed priority is the only arbitration
  always_comb begin
    pick_any = 1'b0;
    pick_seq = 2'h0;
    for (int k = NSEQ - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        pick_any = 1'b1;
        pick_seq = 2'(k);
      end
    end
  end

  assign cur_cfg  = cfg_mem_r[5'(SEQ_BASE[cur_seq_r] + 5'(step_r))];
  assign nxt_cfg  = cfg_mem_r[5'(SEQ_BASE[cur_seq_r] + 5'(step_r) + 5'h1)];
  assign step_ok  = cur_cfg[F_CMP_EN] || fifo_wr_ready[cur_seq_r];
  assign step_end = cur_cfg[F_LAST] || (step_r == SEQ_LAST[cur_seq_r]);

  // Trigger capture; a new trigger beats the clear of the one being started
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_r <= 4'h0;
    end else begin
      for (int k = 0; k < NSEQ; k++) begin
        if (seq_trig[k] && seq_en[k]) begin
          pend_r[k] <= 1'b1;
        end else if (state_r == ST_IDLE && pick_any && pick_seq == 2'(k)) begin
          pend_r[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      cur_seq_r <= 2'h0;
      step_r    <= 3'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (pick_any) begin
            cur_seq_r <= pick_seq;
            step_r    <= 3'h0;
            state_r   <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state_r <= ST_STORE;
          end
        end
        ST_STORE: begin
          // A full FIFO stalls the sequence here until software drains it
          if (step_ok) begin
            if (step_end) begin
              state_r <= ST_IDLE;
            end else begin
              step_r  <= step_r + 3'h1;
              state_r <= ST_CONV;
            end
          end
        end
      endcase
    end
  end

  // Converter request carries the step's settings, loaded as the step starts
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_req_r  <= 1'b0;
      conv_chan_r <= 4'h0;
      conv_diff_r <= 1'b0;
      conv_temp_r <= 1'b0;
    end else if (state_r == ST_IDLE && pick_any) begin
      conv_req_r  <= 1'b1;
      conv_chan_r <= cfg_mem_r[SEQ_BASE[pick_seq]][F_CHAN_MSB:F_CHAN_LSB];
      conv_diff_r <= cfg_mem_r[SEQ_BASE[pick_seq]][F_DIFF];
      conv_temp_r <= cfg_mem_r[SEQ_BASE[pick_seq]][F_TS];
    end else if (state_r == ST_STORE && step_ok && !step_end) begin
      conv_req_r  <= 1'b1;
      conv_chan_r <= nxt_cfg[F_CHAN_MSB:F_CHAN_LSB];
      conv_diff_r <= nxt_cfg[F_DIFF];
      conv_temp_r <= nxt_cfg[F_TS];
    end else if (state_r == ST_CONV && conv_done) begin
      conv_req_r  <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      smp_r <= DATA_RESET;
    end else if (state_r == ST_CONV && conv_done) begin
      smp_r <= conv_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmp_valid_r <= 1'b0;
      cmp_sel_r   <= 3'h0;
      cmp_data_r  <= DATA_RESET;
    end else begin
      cmp_valid_r <= (state_r == ST_STORE) && cur_cfg[F_CMP_EN];
      if (state_r == ST_STORE && cur_cfg[F_CMP_EN]) begin
        cmp_sel_r  <= cur_cfg[F_CMP_MSB:F_CMP_LSB];
        cmp_data_r <= smp_r;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seq_irq_r  <= 4'h0;
      seq_busy_r <= 4'h0;
    end else begin
      for (int k = 0; k < NSEQ; k++) begin
        seq_irq_r[k]  <= (state_r == ST_STORE) && step_ok && cur_cfg[F_IRQ]
                         && cur_seq_r == 2'(k);
        // Busy rises with the first request so it never lags a running conversion
        seq_busy_r[k] <= ((state_r == ST_IDLE) && pick_any && pick_seq == 2'(k))
                         || ((state_r != ST_IDLE) && cur_seq_r == 2'(k));
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSEQ; g++) begin : g_seq
      asc_fifo_if #(.W(DATA_W)) fq ();
      assign fq.wr_valid = (state_r == ST_STORE) && !cur_cfg[F_CMP_EN]
                           && cur_seq_r == 2'(g);
      assign fq.wr_data  = smp_r;
      assign fq.rd_ready = rd_req && rd_seq == 2'(g);
      assign fifo_wr_ready[g]  = fq.wr_ready;
      assign fifo_not_empty[g] = fq.rd_valid;
      assign fifo_rd_data[g]   = fq.rd_data;
      asc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .q       (fq)
      );
    end
  endgenerate

  assign rd_empty = !fifo_not_empty[rd_seq];

  // Empty reads keep the previous data word on the output
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= DATA_RESET;
    end else begin
      rd_valid_r <= rd_req && !rd_empty;
      if (rd_req && !rd_empty) begin
        rd_data_r <= fifo_rd_data[rd_seq];
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle keeps the flag set
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      uflow_r <= 4'h0;
    end else begin
      for (int k = 0; k < NSEQ; k++) begin
        if (rd_req && rd_empty && rd_seq == 2'(k)) begin
          uflow_r[k] <= 1'b1;
        end else if (uflow_clr[k]) begin
          uflow_r[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovf_r <= 4'h0;
    end else begin
      for (int k = 0; k < NSEQ; k++) begin
        if (seq_trig[k] && seq_en[k] && fifo_not_empty[k]) begin
          ovf_r[k] <= 1'b1;
        end else if (ovf_clr[k]) begin
          ovf_r[k] <= 1'b0;
        end
      end
    end
  end
endmodule : asc_step_ctrl
`default_nettype wire

// ==== testbench/asc_step_ctrl_props.sv ====
// Port-level assertions for the sequence step controller
`default_nettype none
module asc_step_ctrl_props (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               conv_req_r,
  input wire logic               conv_diff_r,
  input wire logic               conv_temp_r,
  input wire logic               conv_done,
  input wire logic               cmp_valid_r,
  input wire logic               rd_req,
  input wire logic               rd_valid_r,
  input wire logic [3:0]         conv_chan_r,
  input wire logic [3:0]         seq_irq_r,
  input wire logic [3:0]         seq_busy_r,
  input wire logic [3:0]         seq_trig,
  input wire logic [3:0]         uflow_r,
  input wire logic [3:0]         uflow_clr,
  input wire logic [3:0]         ovf_r,
  input wire logic [3:0]         ovf_clr,
  input wire asc_pkg::asc_data_t conv_data,
  input wire asc_pkg::asc_data_t cmp_data_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_req_hold;
    conv_req_r && !conv_done |=> conv_req_r && $stable(conv_chan_r);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request not held");
  property p_mode_hold;
    conv_req_r && !conv_done |=> $stable({conv_diff_r, conv_temp_r});
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_req_drop; conv_req_r && conv_done |=> !conv_req_r; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request not dropped");
  property p_busy; conv_req_r |-> seq_busy_r != 4'h0; endproperty
  a_busy: assert property (p_busy) else $error("request without busy");
  property p_cmp;
    cmp_valid_r |-> $past(conv_done, 2) && cmp_data_r == $past(conv_data, 2);
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator sample wrong");
  property p_irq; seq_irq_r != 4'h0 |-> $onehot(seq_irq_r) && !$past(conv_req_r); endproperty
  a_irq: assert property (p_irq) else $error("interrupt out of place");
  property p_rd; rd_valid_r |-> $past(rd_req); endproperty
  a_rd: assert property (p_rd) else $error("read without request");
  property p_uf_set;
    (uflow_r & ~$past(uflow_r)) != 4'h0 |-> $past(rd_req) && !rd_valid_r;
  endproperty
  a_uf_set: assert property (p_uf_set) else $error("underflow without empty read");
  property p_uf_keep; ($past(uflow_r) & ~$past(uflow_clr) & ~uflow_r) == 4'h0; endproperty
  a_uf_keep: assert property (p_uf_keep) else $error("underflow lost");
  property p_ovf_keep; ($past(ovf_r) & ~$past(ovf_clr) & ~ovf_r) == 4'h0; endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost");
  property p_ovf_set; (ovf_r & ~$past(ovf_r)) != 4'h0 |-> $past(seq_trig) != 4'h0; endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow without trigger");
endmodule : asc_step_ctrl_props
bind asc_step_ctrl asc_step_ctrl_props asc_step_ctrl_props_i (.*);
`default_nettype wire

// ==== testbench/asc_conv_model.sv ====
// Converter stand-in: answers each request after a short or a long delay
`default_nettype none
module asc_conv_model (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               conv_req_r,
  input wire logic               conv_diff_r,
  input wire logic               conv_temp_r,
  input wire logic               slow,
  input wire logic [3:0]         conv_chan_r,
  output logic                   conv_done,
  output asc_pkg::asc_data_t     conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  logic       fire;
  assign fire = rst_n && conv_req_r && !conv_done && cnt_r >= (slow ? 4'h5 : 4'h0);
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !conv_req_r || conv_done) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
  end
  // Sample encodes the settings; between answers the data inverts every cycle, so a sample taken an odd number of cycles late never matches
  always_ff @(posedge ref_clk) begin
    conv_done <= fire;
    if (!rst_n) conv_data <= 12'h5a5;
    else conv_data <= fire ? {conv_temp_r, conv_diff_r, 6'h00, conv_chan_r} : ~conv_data;
  end
endmodule : asc_conv_model
`default_nettype wire

// ==== testbench/asc_step_ctrl_tb.sv ====
// Self-checking bench for the sequence step controller
`default_nettype none
module asc_step_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asc_pkg::*;
  logic ref_clk, rst_n, cfg_wr, conv_done, rd_req, slow, conv_req_r, conv_diff_r, conv_temp_r;
  logic cmp_valid_r, rd_valid_r;
  logic [3:0] seq_en, seq_trig, uflow_clr, ovf_clr, conv_chan_r, seq_irq_r, seq_busy_r;
  logic [3:0] uflow_r, ovf_r;
  logic [2:0] cmp_sel_r;
  asc_seq_t   sequence_index, rd_seq;
  asc_step_t  step_index;
  asc_cfg_t   step_config_word, w;
  asc_data_t  conv_data, cmp_data_r, rd_data_r;
  asc_cfg_t   cm [4][8];
  asc_data_t  q [4][$];
  logic [14:0] cq [$];
  int fails, check_count, irq_exp, irq_seen, s;
  logic [31:0] seed;
  asc_step_ctrl asc_step_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .sequence_index(sequence_index), .step_index(step_index), .step_config_word(step_config_word),
    .seq_en(seq_en), .seq_trig(seq_trig), .conv_req_r(conv_req_r), .conv_chan_r(conv_chan_r),
    .conv_diff_r(conv_diff_r), .conv_temp_r(conv_temp_r), .conv_done(conv_done),
    .conv_data(conv_data), .cmp_valid_r(cmp_valid_r), .cmp_sel_r(cmp_sel_r),
    .cmp_data_r(cmp_data_r), .seq_irq_r(seq_irq_r), .seq_busy_r(seq_busy_r), .rd_req(rd_req),
    .rd_seq(rd_seq), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .uflow_r(uflow_r),
    .uflow_clr(uflow_clr), .ovf_r(ovf_r), .ovf_clr(ovf_clr));
  asc_conv_model asc_conv_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .conv_req_r(conv_req_r),
    .conv_diff_r(conv_diff_r), .conv_temp_r(conv_temp_r), .slow(slow),
    .conv_chan_r(conv_chan_r), .conv_done(conv_done), .conv_data(conv_data));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic wait_busy(input int k, input logic lvl);
    int n;
    n = 0;
    while (seq_busy_r[k] !== lvl && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 500) begin
      fails++;
      complete_run();
    end
  endtask : wait_busy
  task automatic cfg(input int sq, input int st, input asc_cfg_t cw);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    sequence_index <= 2'(sq);
    step_index <= 3'(st);
    step_config_word <= cw;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    if (3'(st) <= SEQ_LAST[sq]) cm[sq][st] = cw;
  endtask : cfg
  // Predicts the samples from the stored steps before the trigger is sent
  task automatic trig(input int sq);
    asc_data_t d;
    for (int i = 0; i <= int'(SEQ_LAST[sq]); i++) begin
      d = {cm[sq][i][F_TS], cm[sq][i][F_DIFF], 6'h00, cm[sq][i][F_CHAN_MSB:F_CHAN_LSB]};
      if (cm[sq][i][F_IRQ]) irq_exp++;
      if (cm[sq][i][F_CMP_EN]) cq.push_back({cm[sq][i][F_CMP_MSB:F_CMP_LSB], d});
      else q[sq].push_back(d);
      if (cm[sq][i][F_LAST]) break;
    end
    @(posedge ref_clk);
    seq_trig <= 4'h1 << sq;
    slow <= rnd() % 2 == 1;
    @(posedge ref_clk);
    seq_trig <= 4'h0;
    wait_busy(sq, 1'b1);
    wait_busy(sq, 1'b0);
    @(negedge ref_clk);
    chk("irq count", irq_exp, irq_seen);
    chk("comparator backlog", 0, cq.size());
  endtask : trig
  task automatic rd(input int sq);
    asc_data_t e;
    logic emp;
    emp = q[sq].size() == 0;
    if (!emp) e = q[sq].pop_front();
    @(posedge ref_clk);
    rd_req <= 1'b1;
    rd_seq <= 2'(sq);
    @(posedge ref_clk);
    rd_req <= 1'b0;
    @(negedge ref_clk);
    chk("read valid", !emp, rd_valid_r);
    if (emp) chk("underflow", 1, uflow_r[sq]);
    else chk("read data", e, rd_data_r);
  endtask : rd
  task automatic clr(input logic [3:0] u, input logic [3:0] o);
    @(posedge ref_clk);
    uflow_clr <= u;
    ovf_clr <= o;
    @(posedge ref_clk);
    uflow_clr <= 4'h0;
    ovf_clr <= 4'h0;
    @(negedge ref_clk);
  endtask : clr
  always @(negedge ref_clk) begin
    if (rst_n && cmp_valid_r && cq.size() == 0) chk("comparator route", 0, 1);
    else if (rst_n && cmp_valid_r)
      chk("comparator route", cq.pop_front(), {cmp_sel_r, cmp_data_r});
    if (rst_n) irq_seen += $countones(seq_irq_r);
  end
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, cfg_wr, rd_req, slow, seq_trig, uflow_clr, ovf_clr} = '0;
    {sequence_index, step_index, step_config_word, rd_seq} = '0;
    seq_en = 4'hf;
    cm = '{default: '0};
    seed = 32'h01e383a6;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk("reset state", 0, {uflow_r, ovf_r, seq_busy_r, conv_req_r, rd_valid_r});
    // Two runs without reading fill the sequence zero buffer and flag an overflow
    for (int i = 0; i < 8; i++) cfg(0, i, asc_cfg_t'(i));
    trig(0);
    trig(0);
    chk("overflow", 4'h1, ovf_r);
    for (int i = 0; i < 17; i++) rd(0);
    rd(1);
    chk("underflow vector", 4'h3, uflow_r);
    clr(4'h1, 4'h1);
    chk("flags after clear", 8'h20, {uflow_r, ovf_r});
    clr(4'h2, 4'h0);
    // A trigger on a disabled sequence must start nothing
    @(posedge ref_clk);
    seq_en   <= 4'h7;
    seq_trig <= 4'h8;
    @(posedge ref_clk);
    seq_trig <= 4'h0;
    repeat (4) @(posedge ref_clk);
    seq_en <= 4'hf;
    @(negedge ref_clk);
    chk("disabled trigger", 0, {seq_busy_r, conv_req_r, ovf_r});
    $display("test fill and flags done");
    for (int it = 0; it < 16; it++) begin
      s = rnd() % 4;
      repeat (4) begin
        w = asc_cfg_t'(rnd());
        if (w[F_DIFF]) w[F_TS] = 1'b0;
        if (w[F_DIFF]) w[3] = 1'b0;
        cfg(s, rnd() % 8, w);
      end
      trig(s);
      while (q[s].size() > 0) rd(s);
      rd(s);
      clr(4'h1 << s, 4'h0);
      chk("underflow cleared", 0, uflow_r);
      $display("test random %0d done", it);
    end
    complete_run();
  end
endmodule : asc_step_ctrl_tb
`default_nettype wire
